/* src/iqms_regs.svh */
`ifndef IQMS_REGS_SVH
`define IQMS_REGS_SVH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define IQMS_SMP_W        12
`define IQMS_STEP_W       32
`define IQMS_RATE_W       6
`define IQMS_CUBE_W       18
`define IQMS_ADDR_W       4

// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define IQMS_OFS_CTRL     4'h0
`define IQMS_OFS_STEP     4'h4
`define IQMS_OFS_STAT     4'h8

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define IQMS_CTRL_SINC    0
`define IQMS_CTRL_DBL     1
`define IQMS_CTRL_RATE_LO 8
`define IQMS_CTRL_RATE_HI 13
`define IQMS_STAT_SAT     0
`define IQMS_STAT_PH_LO   16
`define IQMS_STAT_PH_HI   27
`define IQMS_RATE_RST     6'h02
`define IQMS_RATE_MIN     6'h02

// ---------------------------------------------------------------
// Datapath constants
// ---------------------------------------------------------------
`define IQMS_PH_LO        26
`define IQMS_PH_HI        31
`define IQMS_QUARTER      32'h4000_0000
`define IQMS_MIX_SHIFT    12
`define IQMS_MIX_PEAK     12'sh5A8
`define IQMS_FIR_TAPS     17
`define IQMS_FIR_SHIFT    10
`define IQMS_SMP_MAX      32'sh0000_07FF
`define IQMS_SMP_MIN      32'shFFFF_F800

`endif

/* src/iqms_pkg.sv */
`include "iqms_regs.svh"

package iqms_pkg;

  typedef logic signed [`IQMS_SMP_W-1:0] iqms_smp_t;

  typedef struct packed {
    logic [`IQMS_STEP_W-1:0] step;
    logic                    sinc_en;
    logic                    dbl;
    logic [`IQMS_RATE_W-1:0] rate;
    logic                    sat_st;
    logic                    ack;
    logic [31:0]             rdata;
    iqms_smp_t               ig;
    iqms_smp_t               qg;
    iqms_smp_t               mix;
    iqms_smp_t               dac;
  } iqms_top_st_t;

  typedef struct packed {
    logic [`IQMS_STEP_W-1:0] phase;
    iqms_smp_t               sin_v;
    iqms_smp_t               cos_v;
  } iqms_syn_st_t;

  typedef struct packed {
    logic [`IQMS_FIR_TAPS-1:0][`IQMS_SMP_W-1:0] tap;
    iqms_smp_t                                  y;
    logic                                       sat;
  } iqms_fir_st_t;

  function automatic logic iqms_ovf(input logic signed [31:0] v);
    return (v > `IQMS_SMP_MAX) || (v < `IQMS_SMP_MIN);
  endfunction : iqms_ovf

  function automatic iqms_smp_t iqms_sat(input logic signed [31:0] v);
    if (v > `IQMS_SMP_MAX) begin
      return iqms_smp_t'(`IQMS_SMP_MAX);
    end else if (v < `IQMS_SMP_MIN) begin
      return iqms_smp_t'(`IQMS_SMP_MIN);
    end
    return iqms_smp_t'(v);
  endfunction : iqms_sat

endpackage : iqms_pkg

/* src/iqms_synth.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iqms_regs.svh"

module iqms_synth
  import iqms_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    ce_in,
  input  wire logic [`IQMS_STEP_W-1:0] step_in,
  output logic      [`IQMS_STEP_W-1:0] phase_out,
  output iqms_smp_t                    sin_out,
  output iqms_smp_t                    cos_out
);

  // ---------------------------------------------------------------
  // Quarter-wave table, mid-bin samples
  // ---------------------------------------------------------------
  localparam logic [11:0] SINE_TAB [16] = '{
    12'h064, 12'h12C, 12'h1F1, 12'h2B2, 12'h36B, 12'h41C, 12'h4C3, 12'h55F,
    12'h5ED, 12'h66C, 12'h6DC, 12'h73A, 12'h787, 12'h7C2, 12'h7E9, 12'h7FD
  };

  function automatic iqms_smp_t wave(input logic [5:0] p);
    logic [3:0]  k;
    logic [11:0] m;
    k = p[4] ? ~p[3:0] : p[3:0];
    m = SINE_TAB[k];
    return p[5] ? iqms_smp_t'(-m) : iqms_smp_t'(m);
  endfunction : wave

  iqms_syn_st_t            q;
  iqms_syn_st_t            d;
  logic [`IQMS_STEP_W-1:0] ph_cos;

  always_comb begin
    d      = q;
    ph_cos = q.phase + `IQMS_QUARTER;
    if (ce_in) begin
      d.phase = q.phase + step_in;
      d.sin_v = wave(q.phase[`IQMS_PH_HI:`IQMS_PH_LO]);
      d.cos_v = wave(ph_cos[`IQMS_PH_HI:`IQMS_PH_LO]);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign phase_out = q.phase;
  assign sin_out   = q.sin_v;
  assign cos_out   = q.cos_v;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_ph_adv;
    ce_in |=> q.phase == $past(q.phase) + $past(step_in);
  endproperty
  a_ph_adv: assert property (p_ph_adv)
    else $error("carrier phase did not advance by the step word");

  property p_quad;
    ce_in |=> (q.sin_v[11] == $past(q.phase[31])) &&
      (q.cos_v[11] == ($past(q.phase[31]) ^ $past(q.phase[30])));
  endproperty
  a_quad: assert property (p_quad)
    else $error("sine and cosine quadrant signs disagree with phase");

endmodule : iqms_synth

`default_nettype wire

/* src/iqms_fir.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iqms_regs.svh"

module iqms_fir
  import iqms_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  input  wire logic      ce_in,
  input  wire iqms_smp_t x_in,
  output iqms_smp_t      y_out,
  output logic           sat_out
);

  // Symmetric inverse-sinc taps, DC gain 717/1024
  localparam logic signed [11:0] COEF [`IQMS_FIR_TAPS] = '{
    12'h001, 12'hFFE, 12'h003, 12'hFFB, 12'h009, 12'hFF0, 12'h021, 12'hFA4,
    12'h357,
    12'hFA4, 12'h021, 12'hFF0, 12'h009, 12'hFFB, 12'h003, 12'hFFE, 12'h001
  };

  iqms_fir_st_t       q;
  iqms_fir_st_t       d;
  logic signed [23:0] prod [`IQMS_FIR_TAPS];
  logic signed [28:0] acc;
  logic signed [31:0] acc_sh;
  logic [4:0]         zrun_q;

  genvar g;
  generate
    for (g = 0; g < `IQMS_FIR_TAPS; g++) begin : g_tap
      assign prod[g] = $signed(q.tap[g]) * COEF[g];
    end
  endgenerate

  always_comb begin
    acc = '0;
    for (int i = 0; i < `IQMS_FIR_TAPS; i++) begin
      acc = acc + 29'(prod[i]);
    end
    acc_sh = 32'(acc >>> `IQMS_FIR_SHIFT);
    d      = q;
    if (ce_in) begin
      d.tap = {q.tap[`IQMS_FIR_TAPS-2:0], x_in};
      d.y   = iqms_sat(acc_sh);
      d.sat = iqms_ovf(acc_sh);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign y_out   = q.y;
  assign sat_out = q.sat;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      zrun_q <= '0;
    end else if (ce_in) begin
      if (x_in != '0) begin
        zrun_q <= '0;
      end else if (zrun_q != 5'h1F) begin
        zrun_q <= zrun_q + 5'h01;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_fir_flush;
    (zrun_q >= 5'(`IQMS_FIR_TAPS)) && ce_in |=> q.y == '0;
  endproperty
  a_fir_flush: assert property (p_fir_flush)
    else $error("filter output not zero after full line of zeros");

endmodule : iqms_fir

`default_nettype wire

/* src/iqms_top.sv */
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "iqms_regs.svh"

module iqms_top
  import iqms_pkg::*;
(
  input  wire logic                    CLK_SYS_IN,
  input  wire logic                    RESETN_IN,
  input  wire logic                    CE_IN,
  input  wire logic [`IQMS_SMP_W-1:0]  I_DATA_IN,
  input  wire logic [`IQMS_SMP_W-1:0]  Q_DATA_IN,
  input  wire logic [`IQMS_ADDR_W-1:0] AVS_ADDRESS_IN,
  input  wire logic                    AVS_READ_IN,
  input  wire logic                    AVS_WRITE_IN,
  input  wire logic [31:0]             AVS_WRITEDATA_IN,
  input  wire logic [3:0]              AVS_BYTEENABLE_IN,
  output logic      [31:0]             AVS_READDATA_OUT,
  output logic                         AVS_WAITREQUEST_OUT,
  output logic      [`IQMS_SMP_W-1:0]  DAC_DATA_OUT
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  localparam iqms_top_st_t ST_RST = '{
    rate    : `IQMS_RATE_RST,
    default : '0
  };

  iqms_top_st_t            q;
  iqms_top_st_t            d;

  logic [`IQMS_STEP_W-1:0] phase_w;
  iqms_smp_t               sin_w;
  iqms_smp_t               cos_w;
  iqms_smp_t               fir_y;
  logic                    fir_sat;

  logic                    req;
  logic                    wr_now;
  logic                    rd_go;
  logic                    clr;
  logic                    sat_evt;
  logic [`IQMS_CUBE_W-1:0] cube;
  logic [4:0]              sh;
  logic signed [31:0]      gi;
  logic signed [31:0]      gq;
  logic signed [31:0]      mx;
  logic [31:0]             ctrl_rd;
  logic [31:0]             stat_rd;
  logic [31:0]             rd_val;
  logic [31:0]             wr_val;
  logic [`IQMS_RATE_W-1:0] rate_wr;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] ceil_log2(
    input logic [`IQMS_CUBE_W-1:0] v
  );
    logic [4:0] r;
    r = '0;
    for (int i = 0; i < `IQMS_CUBE_W; i++) begin
      if ((`IQMS_CUBE_W'(1) << i) < v) begin
        r = 5'(i + 1);
      end
    end
    return r;
  endfunction : ceil_log2

  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // ---------------------------------------------------------------
  // Carrier synthesizer and compensation filter
  // ---------------------------------------------------------------
  iqms_synth iqms_synth_i (
    .clk_in    (CLK_SYS_IN),
    .rst_n_in  (RESETN_IN),
    .ce_in     (CE_IN),
    .step_in   (q.step),
    .phase_out (phase_w),
    .sin_out   (sin_w),
    .cos_out   (cos_w)
  );

  iqms_fir iqms_fir_i (
    .clk_in   (CLK_SYS_IN),
    .rst_n_in (RESETN_IN),
    .ce_in    (CE_IN),
    .x_in     (q.mix),
    .y_out    (fir_y),
    .sat_out  (fir_sat)
  );

  // ---------------------------------------------------------------
  // Datapath and register file
  // ---------------------------------------------------------------
  always_comb begin
    d      = q;
    req    = AVS_READ_IN | AVS_WRITE_IN;
    wr_now = AVS_WRITE_IN & q.ack;
    rd_go  = AVS_READ_IN & ~q.ack;
    clr    = 1'b0;

    // Interpolator gain: R^3 scaled down to the next power of two
    cube = `IQMS_CUBE_W'(q.rate) * `IQMS_CUBE_W'(q.rate)
         * `IQMS_CUBE_W'(q.rate);
    sh   = ceil_log2(cube) - 5'(q.dbl);
    gi   = (32'($signed(I_DATA_IN)) * $signed({14'h0, cube})) >>> sh;
    gq   = (32'($signed(Q_DATA_IN)) * $signed({14'h0, cube})) >>> sh;

    // Quadrature mix; shift removes carrier scale and halves the sum
    mx = (32'($signed(q.ig)) * 32'($signed(cos_w))
        + 32'($signed(q.qg)) * 32'($signed(sin_w)))
        >>> `IQMS_MIX_SHIFT;

    sat_evt = iqms_ovf(gi) | iqms_ovf(gq) | iqms_ovf(mx)
            | (q.sinc_en & fir_sat);

    ctrl_rd = '0;
    ctrl_rd[`IQMS_CTRL_SINC] = q.sinc_en;
    ctrl_rd[`IQMS_CTRL_DBL]  = q.dbl;
    ctrl_rd[`IQMS_CTRL_RATE_HI:`IQMS_CTRL_RATE_LO] = q.rate;

    stat_rd = '0;
    stat_rd[`IQMS_STAT_SAT] = q.sat_st;
    stat_rd[`IQMS_STAT_PH_HI:`IQMS_STAT_PH_LO] =
      phase_w[`IQMS_STEP_W-1 -: `IQMS_SMP_W];

    case (AVS_ADDRESS_IN)
      `IQMS_OFS_CTRL: rd_val = ctrl_rd;
      `IQMS_OFS_STEP: rd_val = q.step;
      `IQMS_OFS_STAT: rd_val = stat_rd;
      default:        rd_val = '0;
    endcase

    wr_val  = be_merge(rd_val, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    rate_wr = wr_val[`IQMS_CTRL_RATE_HI:`IQMS_CTRL_RATE_LO];

    if (CE_IN) begin
      d.ig  = iqms_sat(gi);
      d.qg  = iqms_sat(gq);
      d.mix = iqms_sat(mx);
      d.dac = q.sinc_en ? fir_y : q.mix;
      d.ack = req & ~q.ack;
      if (rd_go) begin
        d.rdata = rd_val;
      end
      if (wr_now) begin
        case (AVS_ADDRESS_IN)
          `IQMS_OFS_CTRL: begin
            d.sinc_en = wr_val[`IQMS_CTRL_SINC];
            d.dbl     = wr_val[`IQMS_CTRL_DBL];
            d.rate    = (rate_wr < `IQMS_RATE_MIN) ? `IQMS_RATE_MIN
                                                   : rate_wr;
          end
          `IQMS_OFS_STEP: begin
            d.step = wr_val;
          end
          `IQMS_OFS_STAT: begin
            clr = AVS_BYTEENABLE_IN[0]
                & AVS_WRITEDATA_IN[`IQMS_STAT_SAT];
          end
          default: begin
          end
        endcase
      end
      // Set wins over a clear in the same cycle
      d.sat_st = (q.sat_st & ~clr) | sat_evt;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign DAC_DATA_OUT        = q.dac;
  assign AVS_READDATA_OUT    = q.rdata;
  assign AVS_WAITREQUEST_OUT = req & ~(q.ack & CE_IN);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);

  logic pow2;
  assign pow2 = (q.rate & (q.rate - `IQMS_RATE_W'(1))) == '0;

  sequence s_step_wr;
    AVS_WRITE_IN && !AVS_WAITREQUEST_OUT
      && (AVS_ADDRESS_IN == `IQMS_OFS_STEP)
      && (AVS_BYTEENABLE_IN == 4'hF);
  endsequence

  sequence s_wait_req;
    req && AVS_WAITREQUEST_OUT && CE_IN;
  endsequence

  property p_step_wr;
    s_step_wr |=> q.step == $past(AVS_WRITEDATA_IN);
  endproperty
  a_step_wr: assert property (p_step_wr)
    else $error("step word not taken from accepted write");

  property p_bus_ans;
    s_wait_req ##1 CE_IN |-> !AVS_WAITREQUEST_OUT;
  endproperty
  a_bus_ans: assert property (p_bus_ans)
    else $error("waitrequest held longer than one cycle");

  property p_gain_unity;
    CE_IN && pow2 && !q.dbl && !AVS_WRITE_IN
      |=> q.ig == $past(I_DATA_IN);
  endproperty
  a_gain_unity: assert property (p_gain_unity)
    else $error("power-of-two rate did not give unity gain");

  property p_gain_dbl;
    CE_IN && pow2 && q.dbl && !AVS_WRITE_IN
      && (I_DATA_IN[11] == I_DATA_IN[10])
      |=> q.ig == {$past(I_DATA_IN[10:0]), 1'b0};
  endproperty
  a_gain_dbl: assert property (p_gain_dbl)
    else $error("doubled gain did not double the sample");

  property p_mix;
    CE_IN |=> q.mix == iqms_sat((32'($signed($past(q.ig)))
      * 32'($signed($past(cos_w))) + 32'($signed($past(q.qg)))
      * 32'($signed($past(sin_w)))) >>> `IQMS_MIX_SHIFT);
  endproperty
  a_mix: assert property (p_mix)
    else $error("modulated sample is not half the product sum");

  property p_bypass;
    CE_IN && !q.sinc_en ##1 CE_IN && !q.sinc_en
      |=> q.dac == $past(q.mix);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass path does not follow the mixer each cycle");

  property p_sinc;
    CE_IN && q.sinc_en |=> q.dac == $past(fir_y);
  endproperty
  a_sinc: assert property (p_sinc)
    else $error("engaged path does not carry the filter output");

  property p_sticky;
    CE_IN && sat_evt |=> q.sat_st;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("saturation event lost from status");

  property p_freeze;
    !CE_IN |=> $stable(q.dac) && $stable(q.step);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  sequence s_step_rd;
    AVS_READ_IN && !AVS_WAITREQUEST_OUT
      && (AVS_ADDRESS_IN == `IQMS_OFS_STEP);
  endsequence

  property p_step_rd;
    s_step_rd |-> AVS_READDATA_OUT == q.step;
  endproperty
  a_step_rd: assert property (p_step_rd)
    else $error("step word read back differs from register");

  property p_gain_att;
    CE_IN && !pow2 && !q.dbl && !I_DATA_IN[11] && (I_DATA_IN != '0)
      |=> (q.ig < $past(I_DATA_IN))
      && (q.ig >= ($past(I_DATA_IN) >> 1));
  endproperty
  a_gain_att: assert property (p_gain_att)
    else $error("non power-of-two gain outside half to unity");

  property p_gain_sat;
    CE_IN && (gi > `IQMS_SMP_MAX) |=> q.ig == iqms_smp_t'(`IQMS_SMP_MAX);
  endproperty
  a_gain_sat: assert property (p_gain_sat)
    else $error("gain overflow did not saturate");

  property p_half;
    CE_IN |=> (q.mix <= `IQMS_MIX_PEAK) && (q.mix >= -`IQMS_MIX_PEAK);
  endproperty
  a_half: assert property (p_half)
    else $error("modulated sample exceeds halved peak");

endmodule : iqms_top

`default_nettype wire

/* bench/iqms_iq_src.sv */
`timescale 1ns/1ps
`default_nettype none

module iqms_iq_src (
  input  wire logic        clk_in,
  input  wire logic        ce_in,
  input  wire logic        rnd_in,
  input  wire logic        dbl_in,
  input  wire logic [11:0] fix_in,
  output logic      [11:0] i_out,
  output logic      [11:0] q_out
);
  logic [11:0] ri;
  logic [11:0] rq;

  initial begin
    i_out = 12'h000;
    q_out = 12'h000;
  end

  // ---------------------------------------------------------------
  // New pair only on enabled edges
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    if (ce_in) begin
      ri = 12'($urandom);
      rq = 12'($urandom);
      if (dbl_in) begin
        ri = {ri[11], ri[11:1]};
        rq = {rq[11], rq[11:1]};
      end
      i_out <= rnd_in ? ri : fix_in;
      q_out <= rnd_in ? rq : fix_in;
    end
  end
endmodule : iqms_iq_src

`default_nettype wire

/* bench/iqms_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module iqms_top_tb;
  typedef struct { int due; logic [11:0] v; } iqms_dq_t;
  typedef struct { logic [31:0] v; logic [31:0] m; } iqms_rq_t;
  localparam int CF [17] = '{1, -2, 3, -5, 9, -16, 33, -92, 855,
                             -92, 33, -16, 9, -5, 3, -2, 1};
  localparam int RT [7] = '{2, 3, 4, 5, 7, 51, 63};
  // Carrier cosine and sine at zero phase
  localparam int CW = 2045;
  localparam int SW = 100;
  localparam logic [31:0] ST [2] = '{32'h0010_0000, 32'h0070_0000};

  logic        clk = 1'b0;
  logic        rst_n, ce, ce_rnd, rnd, dbl, sinc, arm, rd, wr;
  logic [11:0] i_d, q_d, dac, fix;
  logic [3:0]  adr, ben;
  logic [31:0] wdat, rdat_o, rdat, p1;
  logic        wait_o;
  int          cyc = 0;
  int          rate, acc, err_total, checks_done;
  int          mh [17];
  iqms_dq_t    dq [$];
  iqms_rq_t    rq [$];
  iqms_dq_t    e;
  iqms_rq_t    r;

  iqms_top iqms_top_i (.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .CE_IN(ce),
    .I_DATA_IN(i_d), .Q_DATA_IN(q_d), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat),
    .AVS_BYTEENABLE_IN(ben), .AVS_READDATA_OUT(rdat_o),
    .AVS_WAITREQUEST_OUT(wait_o), .DAC_DATA_OUT(dac));

  iqms_iq_src iqms_iq_src_i (.clk_in(clk), .ce_in(ce), .rnd_in(rnd),
    .dbl_in(dbl), .fix_in(fix), .i_out(i_d), .q_out(q_d));

  always #50 clk = ~clk;

  always @(posedge clk) begin
    ce <= ce_rnd ? ($urandom % 8 != 0) : 1'b1;
    if (ce) cyc <= cyc + 1;
  end

  // ---------------------------------------------------------------
  // Reference model and checking
  // ---------------------------------------------------------------
  function automatic int sat12(int v);
    return v > 2047 ? 2047 : (v < -2048 ? -2048 : v);
  endfunction : sat12

  function automatic int gn(int x);
    int c;
    c = rate * rate * rate;
    return sat12((x * c) >>> ($clog2(c) - int'(dbl)));
  endfunction : gn

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  always @(negedge clk) begin
    if (rst_n && ce) begin
      for (int k = 16; k > 0; k--) mh[k] = mh[k-1];
      mh[0] = (gn($signed(i_d)) * CW + gn($signed(q_d)) * SW) >>> 12;
      acc = 0;
      foreach (CF[k]) acc += CF[k] * mh[k];
      if (arm) dq.push_back('{sinc ? cyc + 5 : cyc + 3,
                              12'(sinc ? sat12(acc >>> 10) : mh[0])});
    end
  end

  always @(negedge clk) begin
    if (dq.size() > 0 && dq[0].due <= cyc) begin
      e = dq.pop_front();
      chk({20'h0, dac}, {20'h0, e.v});
    end
    if (rd && !wait_o && rq.size() > 0) begin
      r = rq.pop_front();
      chk(rdat_o & r.m, r.v & r.m);
    end
  end

  // ---------------------------------------------------------------
  // Bus master and sequence
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= d;
    ben <= b;
    while (!done) begin
      @(posedge clk);
      done = !wait_o;
      rdat = rdat_o;
      n++;
      if (n > 100) begin
        err_total++;
        finish_test();
      end
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rdc(input logic [3:0] a, input logic [31:0] v,
                     input logic [31:0] m);
    rq.push_back('{v, m});
    bus(1'b0, a, 32'h0, 4'hF);
  endtask : rdc

  task automatic setc(input int rt, input logic db, input logic sn);
    arm = 1'b0;
    repeat (12) @(posedge clk);
    bus(1'b1, 4'h0, (32'(rt) << 8) | {30'h0, db, sn}, 4'hF);
    rate = rt;
    dbl <= db;
    sinc = sn;
    repeat (40) @(posedge clk);
    arm = 1'b1;
  endtask : setc

  task finish_test();
    $display("TB: checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    #5_000_000;
    err_total++;
    finish_test();
  end

  initial begin
    {rst_n, ce, ce_rnd, rnd, dbl, sinc, arm, rd, wr} = 9'h000;
    {adr, ben, wdat, fix} = 52'h0;
    rate = 2;
    void'($urandom(32'h4D10));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(4'h0, 32'h0000_0200, 32'hFFFF_FFFF);
    rdc(4'h4, 32'h0, 32'hFFFF_FFFF);
    rdc(4'h8, 32'h0, 32'hFFFF_FFFF);
    rdc(4'hC, 32'h0, 32'hFFFF_FFFF);
    $display("TB: test reset_values done");
    rnd <= 1'b1;
    ce_rnd <= 1'b1;
    foreach (RT[j]) for (int s = 0; s < 4; s++) begin
      setc(RT[j], s[0], s[1]);
      repeat (40) @(posedge clk);
    end
    $display("TB: test stream_sweep done");
    {ce_rnd, rnd} <= 2'b00;
    fix <= 12'h7FF;
    setc(2, 1'b1, 1'b0);
    rdc(4'h8, 32'h1, 32'h1);
    fix <= 12'h000;
    setc(2, 1'b0, 1'b0);
    bus(1'b1, 4'h8, 32'h0, 4'hF);
    rdc(4'h8, 32'h1, 32'h1);
    bus(1'b1, 4'h8, 32'h1, 4'hF);
    rdc(4'h8, 32'h0, 32'h1);
    $display("TB: test saturation done");
    arm = 1'b0;
    foreach (ST[j]) begin
      bus(1'b1, 4'h4, ST[j], 4'hF);
      bus(1'b0, 4'h8, 32'h0, 4'hF);
      p1 = rdat;
      bus(1'b0, 4'h8, 32'h0, 4'hF);
      chk((rdat - p1) >> 16 & 32'hFFF, (3 * ST[j]) >> 20 & 32'hFFF);
    end
    $display("TB: test carrier_step done");
    bus(1'b1, 4'h0, 32'h0000_0103, 4'hF);
    rdc(4'h0, 32'h0000_0203, 32'h0000_3F03);
    bus(1'b1, 4'h4, 32'hFFFF_FFFF, 4'hF);
    bus(1'b1, 4'h4, 32'h1234_5678, 4'h3);
    rdc(4'h4, 32'hFFFF_5678, 32'hFFFF_FFFF);
    bus(1'b1, 4'hC, 32'h0000_0000, 4'hF);
    rdc(4'h0, 32'h0000_0203, 32'h0000_3F03);
    $display("TB: test registers done");
    finish_test();
  end
endmodule : iqms_top_tb

`default_nettype wire
